/* hw/otg_pkg.sv */
// Purpose: Shared constants, register map and states of the OTG role logic.
// Assumes: 40 MHz core clock; all timing figures are held in microseconds.
// Notes: Cycle counts are derived from the microsecond figures below.
package otg_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // Idle-before-disconnect wait in a_suspend; must exceed 150 ms.
  localparam int unsigned AIDL_BDIS_US = 160_000;
  localparam int unsigned AIDL_BDIS_CYC = AIDL_BDIS_US * CYC_PER_US;
  // Idle in a_peripheral: strictly more than 3 ms, forced at 200 ms.
  localparam int unsigned BIDL_MIN_US = 3_000;
  localparam int unsigned BIDL_MIN_CYC = BIDL_MIN_US * CYC_PER_US + 1;
  localparam int unsigned BIDL_MAX_US = 200_000;
  localparam int unsigned BIDL_MAX_CYC = BIDL_MAX_US * CYC_PER_US;
  localparam int unsigned SE0_SRP_US = 2_000;
  localparam int unsigned SE0_SRP_CYC = SE0_SRP_US * CYC_PER_US;
  // Session request signalling length; must stay below 100 ms.
  localparam int unsigned SRP_INIT_US = 90_000;
  localparam int unsigned SRP_INIT_CYC = SRP_INIT_US * CYC_PER_US;
  // Vendor failure limit, chosen inside the 5 s to 30 s window.
  localparam int unsigned SRP_FAIL_US = 10_000_000;
  localparam int unsigned SRP_FAIL_CYC = SRP_FAIL_US * CYC_PER_US;
  localparam int unsigned ASE0_BRST_US = 3_125;
  localparam int unsigned ASE0_BRST_CYC = ASE0_BRST_US * CYC_PER_US;
  // Bus reset drive; longer than 10 ms.
  localparam int unsigned BUS_RST_US = 11_000;
  localparam int unsigned BUS_RST_CYC = BUS_RST_US * CYC_PER_US;
  // Reset sample point after the pull-up is enabled.
  localparam int unsigned RST_SMP_US = 100;
  localparam int unsigned RST_SMP_CYC = RST_SMP_US * CYC_PER_US;

  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] CMD_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam int unsigned CTRL_W = 10;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam int unsigned C_A_BUS_REQ = 0;
  localparam int unsigned C_A_BUS_DROP = 1;
  localparam int unsigned C_A_HNP_SET = 2;
  localparam int unsigned C_B_BUS_REQ = 3;
  localparam int unsigned C_B_HNP_EN = 4;
  localparam int unsigned C_PERIPH_ONLY = 5;
  localparam int unsigned C_HS_CAP = 6;
  localparam int unsigned C_HS_MODE = 7;
  localparam int unsigned C_IDLE_EXIT = 8;
  localparam int unsigned C_A_SUSP_REQ = 9;
  localparam int unsigned K_CLR_ERR = 0;
  localparam int unsigned K_CLR_FAIL = 1;
  localparam int unsigned S_LOC_CONN = 16;
  localparam int unsigned S_LOC_SOF = 17;
  localparam int unsigned S_DRV_SE0 = 18;
  localparam int unsigned S_DRV_VBUS = 19;
  localparam int unsigned S_SRP_DRV = 20;
  localparam int unsigned S_SRP_IND = 21;
  localparam int unsigned S_SRP_FAIL = 22;
  localparam int unsigned SYNC_W = 11;
  // The cable-id bit (top) resets high so the port starts as a B-device.
  localparam logic [10:0] SYNC_RST = 11'h400;

  typedef enum logic [12:0] {
    a_idle = 13'h0001, a_wait_vrise = 13'h0002, a_wait_bcon = 13'h0004,
    a_host = 13'h0008, a_suspend = 13'h0010, a_peripheral = 13'h0020,
    a_wait_vfall = 13'h0040, a_vbus_err = 13'h0080, b_idle = 13'h0100,
    b_srp_init = 13'h0200, b_peripheral = 13'h0400,
    b_wait_acon = 13'h0800, b_host = 13'h1000
  } otg_state_e;
endpackage : otg_pkg

/* hw/otg_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous comparator inputs.
// Assumes: Inputs are quasi-static levels.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module otg_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_q <= RST;
      dout <= RST;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : otg_sync

/* hw/otg_timer.sv */
// Purpose: Saturating run-time counter that flags a fixed limit.
// Assumes: run is high while the timed condition holds.
// Notes: Dropping run clears the count, so each entry starts from zero.
`timescale 1ns/1ps
module otg_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run,
  output logic done
);
  logic [31:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (!nrst || !run) begin
      cnt_q <= 32'h0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign done = (cnt_q == LIMIT);
endmodule : otg_timer

/* hw/otg_role_fsm.sv */
// Purpose: Dual-role OTG role negotiation state machine with APB control.
// Assumes: Comparator and line-state pins are asynchronous levels.
// Notes: Timers are parameters so simulations can shorten them.
`timescale 1ns/1ps
// Behaviour
// - Suspend starts idle timer exceeding 150 ms.
// - Suspend timeout, drop or id go vfall.
// - Disconnect in suspend: peripheral or wait_bcon.
// - Request or resume returns to host.
// - Lost VBUS in suspend/peripheral: vbus error.
// - Only peripheral states assert connect.
// - Peripheral exits to vfall on id/drop.
// - Peripheral idle 3 ms may, 200 ms must.
// - Vfall waits session end; id/drop force vfall.
// - VBUS error holds until clear request, id or drop.
// - B idle: session valid or A plug.
// - SRP needs request, session end, 2 ms SE0.
// - SRP signalling ends below 100 ms.
// - SRP indication and failure timer.
// - Request, HNP enable, suspend: wait_acon.
// - Id or session loss returns to b_idle.
// - Pull-up on; sampled SE0 starts HS detect.
// - Wait_acon drops pull-up, timer or K back.
// - A connect before timeout enters b_host.
// - Host resets bus, SOF until release.
module otg_role_fsm #(
  parameter int unsigned AIDL_CYC = otg_pkg::AIDL_BDIS_CYC,
  parameter int unsigned BMIN_CYC = otg_pkg::BIDL_MIN_CYC,
  parameter int unsigned BMAX_CYC = otg_pkg::BIDL_MAX_CYC,
  parameter int unsigned SE0_CYC = otg_pkg::SE0_SRP_CYC,
  parameter int unsigned SRP_CYC = otg_pkg::SRP_INIT_CYC,
  parameter int unsigned FAIL_CYC = otg_pkg::SRP_FAIL_CYC,
  parameter int unsigned BRST_CYC = otg_pkg::ASE0_BRST_CYC,
  parameter int unsigned RST_CYC = otg_pkg::BUS_RST_CYC,
  parameter int unsigned SMP_CYC = otg_pkg::RST_SMP_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic id_pin,
  input wire logic a_vbus_vld_pin,
  input wire logic a_sess_vld_pin,
  input wire logic b_sess_vld_pin,
  input wire logic b_sess_end_pin,
  input wire logic b_conn_pin,
  input wire logic a_conn_pin,
  input wire logic se0_pin,
  input wire logic j_pin,
  input wire logic k_pin,
  input wire logic srp_det_pin,
  output logic loc_conn,
  output logic loc_sof,
  output logic drv_se0,
  output logic drv_vbus,
  output logic srp_drive,
  output logic srp_ind,
  output logic srp_fail,
  output logic hs_det_start
);
  otg_pkg::otg_state_e state_q, state_d;
  logic [otg_pkg::CTRL_W-1:0] ctrl_q;
  logic id_s, a_vbus_vld_s, a_sess_vld_s, b_sess_vld_s, b_sess_end_s;
  logic b_conn_s, a_conn_s, se0_s, j_s, k_s, srp_det_s;
  logic a_bus_req, a_bus_drop, a_set_hnp, b_bus_req, b_hnp_en;
  logic periph_only, hs_cap, hs_mode, idle_exit, a_susp_req;
  logic id_drop, b_lost, idle_line, in_periph, host_d, enter_host;
  logic aidl_done, bmin_done, bmax_done, se0_done, srp_done;
  logic fail_done, brst_done, rst_done, smp_done, smp_seen_q;
  logic clr_err_q, srp_wait_q, wr, cmd_wr;
  logic [31:0] rdata;

  otg_sync #(.W(otg_pkg::SYNC_W), .RST(otg_pkg::SYNC_RST)) u_sync (
    .core_clk(core_clk), .nrst(nrst),
    .din({id_pin, a_vbus_vld_pin, a_sess_vld_pin, b_sess_vld_pin,
          b_sess_end_pin, b_conn_pin, a_conn_pin, se0_pin, j_pin, k_pin,
          srp_det_pin}),
    .dout({id_s, a_vbus_vld_s, a_sess_vld_s, b_sess_vld_s, b_sess_end_s,
           b_conn_s, a_conn_s, se0_s, j_s, k_s, srp_det_s}));

  assign a_bus_req = ctrl_q[otg_pkg::C_A_BUS_REQ];
  assign a_bus_drop = ctrl_q[otg_pkg::C_A_BUS_DROP];
  assign a_set_hnp = ctrl_q[otg_pkg::C_A_HNP_SET];
  assign b_bus_req = ctrl_q[otg_pkg::C_B_BUS_REQ];
  assign b_hnp_en = ctrl_q[otg_pkg::C_B_HNP_EN];
  assign periph_only = ctrl_q[otg_pkg::C_PERIPH_ONLY];
  assign hs_cap = ctrl_q[otg_pkg::C_HS_CAP];
  assign hs_mode = ctrl_q[otg_pkg::C_HS_MODE];
  assign idle_exit = ctrl_q[otg_pkg::C_IDLE_EXIT];
  assign a_susp_req = ctrl_q[otg_pkg::C_A_SUSP_REQ];

  assign id_drop = id_s || a_bus_drop;
  // A peripheral-only device ignores the cable id.
  assign b_lost = (!id_s && !periph_only) || !b_sess_vld_s;
  assign idle_line = hs_mode ? se0_s : j_s;
  assign in_periph = (state_q == otg_pkg::a_peripheral) ||
                     (state_q == otg_pkg::b_peripheral);

  otg_timer #(.LIMIT(AIDL_CYC)) u_aidl (.core_clk(core_clk), .nrst(nrst),
    .run(state_q == otg_pkg::a_suspend), .done(aidl_done));
  otg_timer #(.LIMIT(BMIN_CYC)) u_bmin (.core_clk(core_clk), .nrst(nrst),
    .run(idle_line && in_periph), .done(bmin_done));
  otg_timer #(.LIMIT(BMAX_CYC)) u_bmax (.core_clk(core_clk), .nrst(nrst),
    .run(idle_line && in_periph), .done(bmax_done));
  otg_timer #(.LIMIT(SE0_CYC)) u_se0 (.core_clk(core_clk), .nrst(nrst),
    .run(se0_s && state_q == otg_pkg::b_idle), .done(se0_done));
  otg_timer #(.LIMIT(SRP_CYC)) u_srp (.core_clk(core_clk), .nrst(nrst),
    .run(state_q == otg_pkg::b_srp_init), .done(srp_done));
  otg_timer #(.LIMIT(FAIL_CYC)) u_fail (.core_clk(core_clk), .nrst(nrst),
    .run(srp_wait_q), .done(fail_done));
  otg_timer #(.LIMIT(BRST_CYC)) u_brst (.core_clk(core_clk), .nrst(nrst),
    .run(state_q == otg_pkg::b_wait_acon), .done(brst_done));
  otg_timer #(.LIMIT(RST_CYC)) u_rst (.core_clk(core_clk), .nrst(nrst),
    .run(drv_se0), .done(rst_done));
  otg_timer #(.LIMIT(SMP_CYC)) u_smp (.core_clk(core_clk), .nrst(nrst),
    .run(se0_s && loc_conn && hs_cap), .done(smp_done));

  // Exits are tested in priority order, evaluated on every clock.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      otg_pkg::a_idle: begin
        if (id_s) state_d = otg_pkg::b_idle;
        else if (!a_bus_drop && (a_bus_req || srp_det_s))
          state_d = otg_pkg::a_wait_vrise;
      end
      otg_pkg::a_wait_vrise: begin
        if (id_drop) state_d = otg_pkg::a_wait_vfall;
        else if (a_vbus_vld_s) state_d = otg_pkg::a_wait_bcon;
      end
      otg_pkg::a_wait_bcon: begin
        if (id_drop) state_d = otg_pkg::a_wait_vfall;
        else if (!a_vbus_vld_s) state_d = otg_pkg::a_vbus_err;
        else if (b_conn_s) state_d = otg_pkg::a_host;
      end
      otg_pkg::a_host: begin
        if (id_drop) state_d = otg_pkg::a_wait_vfall;
        else if (!a_vbus_vld_s) state_d = otg_pkg::a_vbus_err;
        else if (!b_conn_s) state_d = otg_pkg::a_wait_bcon;
        else if (a_susp_req) state_d = otg_pkg::a_suspend;
      end
      otg_pkg::a_suspend: begin
        if (id_drop) state_d = otg_pkg::a_wait_vfall;
        else if (!a_vbus_vld_s) state_d = otg_pkg::a_vbus_err;
        else if (aidl_done) state_d = otg_pkg::a_wait_vfall;
        else if (!b_conn_s) state_d = a_set_hnp ? otg_pkg::a_peripheral
                                                : otg_pkg::a_wait_bcon;
        else if (a_bus_req || k_s) state_d = otg_pkg::a_host;
      end
      otg_pkg::a_peripheral: begin
        if (id_drop) state_d = otg_pkg::a_wait_vfall;
        else if (!a_vbus_vld_s) state_d = otg_pkg::a_vbus_err;
        else if (bmax_done || (idle_exit && bmin_done))
          state_d = otg_pkg::a_wait_bcon;
      end
      otg_pkg::a_wait_vfall: begin
        if (!a_sess_vld_s) state_d = otg_pkg::a_idle;
      end
      otg_pkg::a_vbus_err: begin
        if (id_drop || clr_err_q) state_d = otg_pkg::a_wait_vfall;
      end
      otg_pkg::b_idle: begin
        if (!id_s && !periph_only) state_d = otg_pkg::a_idle;
        else if (b_sess_vld_s) state_d = otg_pkg::b_peripheral;
        else if (b_bus_req && b_sess_end_s && se0_done)
          state_d = otg_pkg::b_srp_init;
      end
      otg_pkg::b_srp_init: begin
        if (srp_done) state_d = otg_pkg::b_idle;
      end
      otg_pkg::b_peripheral: begin
        if (b_lost) state_d = otg_pkg::b_idle;
        else if (!periph_only && b_bus_req && b_hnp_en && bmin_done)
          state_d = otg_pkg::b_wait_acon;
      end
      otg_pkg::b_wait_acon: begin
        if (b_lost) state_d = otg_pkg::b_idle;
        else if (brst_done || k_s) state_d = otg_pkg::b_peripheral;
        else if (a_conn_s) state_d = otg_pkg::b_host;
      end
      otg_pkg::b_host: begin
        if (b_lost) state_d = otg_pkg::b_idle;
        else if (!b_bus_req || !a_conn_s)
          state_d = otg_pkg::b_peripheral;
      end
      default: state_d = otg_pkg::b_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) state_q <= otg_pkg::b_idle;
    else state_q <= state_d;
  end

  assign host_d = (state_d == otg_pkg::a_host) ||
                  (state_d == otg_pkg::b_host);
  // A remote resume from a_suspend needs no reset from us.
  assign enter_host = host_d && (state_d != state_q) &&
                      !(state_q == otg_pkg::a_suspend && !a_bus_req);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      loc_conn <= 1'b0;
      drv_vbus <= 1'b0;
      srp_drive <= 1'b0;
    end else begin
      loc_conn <= (state_d == otg_pkg::a_peripheral) ||
                  (state_d == otg_pkg::b_peripheral);
      drv_vbus <= (state_d == otg_pkg::a_wait_vrise) ||
                  (state_d == otg_pkg::a_wait_bcon) ||
                  (state_d == otg_pkg::a_host) ||
                  (state_d == otg_pkg::a_suspend) ||
                  (state_d == otg_pkg::a_peripheral);
      srp_drive <= (state_d == otg_pkg::b_srp_init);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) drv_se0 <= 1'b0;
    else if (enter_host) drv_se0 <= 1'b1;
    else if (rst_done || !host_d) drv_se0 <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) loc_sof <= 1'b0;
    else loc_sof <= host_d && !enter_host && !(drv_se0 && !rst_done);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      smp_seen_q <= 1'b0;
      hs_det_start <= 1'b0;
    end else begin
      smp_seen_q <= smp_done;
      hs_det_start <= smp_done && !smp_seen_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) srp_wait_q <= 1'b0;
    else if (state_q != otg_pkg::b_srp_init &&
             state_d == otg_pkg::b_srp_init) srp_wait_q <= 1'b1;
    else if (fail_done || state_d == otg_pkg::b_peripheral ||
             state_d == otg_pkg::a_idle) srp_wait_q <= 1'b0;
  end

  // Failure flag is sticky; a new failure beats a software clear.
  always_ff @(posedge core_clk) begin
    if (!nrst) srp_fail <= 1'b0;
    else if (fail_done) srp_fail <= 1'b1;
    else if (cmd_wr && pwdata[otg_pkg::K_CLR_FAIL]) srp_fail <= 1'b0;
  end

  assign srp_ind = srp_wait_q;
  assign wr = psel && penable && pwrite;
  assign cmd_wr = wr && (paddr == otg_pkg::CMD_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != otg_pkg::CTRL_OFF) &&
                   (paddr != otg_pkg::CMD_OFF) && (paddr != otg_pkg::STAT_OFF);

  always_ff @(posedge core_clk) begin
    if (!nrst) ctrl_q <= otg_pkg::CTRL_RST;
    else if (wr && paddr == otg_pkg::CTRL_OFF)
      ctrl_q <= pwdata[otg_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) clr_err_q <= 1'b0;
    else clr_err_q <= cmd_wr && pwdata[otg_pkg::K_CLR_ERR];
  end

  always_comb begin
    rdata = 32'h0;
    if (paddr == otg_pkg::CTRL_OFF) begin
      rdata[otg_pkg::CTRL_W-1:0] = ctrl_q;
    end else if (paddr == otg_pkg::STAT_OFF) begin
      rdata[12:0] = state_q;
      rdata[otg_pkg::S_LOC_CONN] = loc_conn;
      rdata[otg_pkg::S_LOC_SOF] = loc_sof;
      rdata[otg_pkg::S_DRV_SE0] = drv_se0;
      rdata[otg_pkg::S_DRV_VBUS] = drv_vbus;
      rdata[otg_pkg::S_SRP_DRV] = srp_drive;
      rdata[otg_pkg::S_SRP_IND] = srp_ind;
      rdata[otg_pkg::S_SRP_FAIL] = srp_fail;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) prdata <= 32'h0;
    else if (psel && !penable) prdata <= rdata;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_aidl_hold;
    state_q == otg_pkg::a_suspend && !id_drop && a_vbus_vld_s && b_conn_s &&
    !a_bus_req && !k_s && !aidl_done |=> state_q == otg_pkg::a_suspend;
  endproperty
  a_aidl_hold: assert property (p_aidl_hold) else $error("early exit");
  property p_susp_vfall;
    state_q == otg_pkg::a_suspend && (id_drop || (aidl_done && a_vbus_vld_s))
    |=> state_q == otg_pkg::a_wait_vfall;
  endproperty
  a_susp_vfall: assert property (p_susp_vfall) else $error("no vfall");
  property p_susp_disc;
    state_q == otg_pkg::a_suspend && !id_drop && a_vbus_vld_s && !aidl_done &&
    !b_conn_s |=> state_q == ($past(a_set_hnp) ? otg_pkg::a_peripheral
                                               : otg_pkg::a_wait_bcon);
  endproperty
  a_susp_disc: assert property (p_susp_disc) else $error("bad disconnect");
  property p_susp_host;
    state_q == otg_pkg::a_suspend && !id_drop && a_vbus_vld_s && !aidl_done &&
    b_conn_s && (a_bus_req || k_s)
    |=> state_q == otg_pkg::a_host && drv_se0 == $past(a_bus_req);
  endproperty
  a_susp_host: assert property (p_susp_host) else $error("bad resume");
  property p_vbus_err;
    in_periph && state_q != otg_pkg::b_peripheral && !id_drop && !a_vbus_vld_s
    ##0 1'b1 or state_q == otg_pkg::a_suspend && !id_drop && !a_vbus_vld_s
    |=> state_q == otg_pkg::a_vbus_err;
  endproperty
  a_vbus_err: assert property (p_vbus_err) else $error("no vbus error");
  property p_conn;
    loc_conn == in_periph;
  endproperty
  a_conn: assert property (p_conn) else $error("connect outside peripheral");
  property p_idle_max;
    state_q == otg_pkg::a_peripheral && !id_drop && a_vbus_vld_s &&
    bmax_done |=> state_q == otg_pkg::a_wait_bcon;
  endproperty
  a_idle_max: assert property (p_idle_max) else $error("idle exit missed");
  property p_err_hold;
    state_q == otg_pkg::a_vbus_err && !id_drop && !clr_err_q
    |=> state_q == otg_pkg::a_vbus_err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error left early");
  property p_srp_entry;
    $rose(state_q == otg_pkg::b_srp_init)
    |-> $past(b_bus_req && b_sess_end_s && se0_done);
  endproperty
  a_srp_entry: assert property (p_srp_entry) else $error("bad srp entry");
  property p_fail;
    $rose(srp_fail) |-> $past(fail_done) && !srp_ind;
  endproperty
  a_fail: assert property (p_fail) else $error("bad failure flag");
  property p_wacon;
    state_q == otg_pkg::b_wait_acon |-> !loc_conn;
  endproperty
  a_wacon: assert property (p_wacon) else $error("pull-up left on");
  property p_acon;
    state_q == otg_pkg::b_wait_acon && !b_lost && !brst_done && !k_s &&
    a_conn_s |=> state_q == otg_pkg::b_host ##1 drv_se0;
  endproperty
  a_acon: assert property (p_acon) else $error("b_host not entered");
  property p_host_end;
    state_q == otg_pkg::b_host && !b_lost && (!b_bus_req || !a_conn_s)
    |=> state_q == otg_pkg::b_peripheral && !loc_sof;
  endproperty
  a_host_end: assert property (p_host_end) else $error("sof not stopped");
endmodule : otg_role_fsm

/* tb/remote_dev.sv */
// Purpose: Remote cable partner driving line state and the A connect.
// Assumes: The bench sets acc and se0_req at rising edges.
// Notes: The connect follows the local disconnect by DLY+1 cycles.
`timescale 1ns/1ps
module remote_dev #(
  parameter int unsigned DLY = 3
) (
  input wire logic core_clk,
  input wire logic acc,
  input wire logic se0_req,
  input wire logic loc_conn,
  input wire logic drv_se0,
  output logic a_conn,
  output logic se0,
  output logic j
);
  int unsigned cnt;
  always_ff @(posedge core_clk) begin
    cnt <= (acc && !loc_conn) ? cnt + 1 : 0;
    a_conn <= acc && (a_conn || cnt >= DLY);
  end
  assign se0 = drv_se0 || se0_req;
  assign j = !se0;
endmodule : remote_dev

/* tb/otg_role_state_machine_bench.sv */
// Purpose: Self-checking bench for the OTG role logic.
// Assumes: Timer parameters cut to a few tens of cycles.
// Notes: Pins change at rising edges; outputs are read at falling edges, except prdata and pslverr, read at rising edges.
`timescale 1ns/1ps
module otg_role_state_machine_bench;
  localparam logic [11:0] CT = otg_pkg::CTRL_OFF;
  localparam logic [11:0] SA = otg_pkg::STAT_OFF;
  localparam int SRPC = 12;
  localparam int RSTC = 10;
  logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, st;
  logic id = 1, avv = 0, asv = 0, bsv = 0, bse = 0, bc = 0, sq = 0, acc = 0;
  logic k_line = 0, srp_det = 0;
  logic pready, pslverr, perr, a_conn, se0, j, hs, loc_conn, loc_sof;
  logic drv_se0, drv_vbus, srp_drive, srp_ind, srp_fail;
  int fail_count = 0, n_tests = 0, n;
  always #12.5 core_clk = !core_clk;
  otg_role_fsm #(.AIDL_CYC(20), .BMIN_CYC(10), .BMAX_CYC(30), .SE0_CYC(8),
    .SRP_CYC(SRPC), .FAIL_CYC(60), .BRST_CYC(15), .RST_CYC(RSTC),
    .SMP_CYC(5)) dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .id_pin(id), .a_vbus_vld_pin(avv),
    .a_sess_vld_pin(asv), .b_sess_vld_pin(bsv), .b_sess_end_pin(bse),
    .b_conn_pin(bc), .a_conn_pin(a_conn), .se0_pin(se0), .j_pin(j),
    .k_pin(k_line), .srp_det_pin(srp_det), .loc_conn, .loc_sof, .drv_se0,
    .drv_vbus, .srp_drive, .srp_ind, .srp_fail, .hs_det_start(hs));
  remote_dev #(.DLY(8)) peer (.core_clk, .acc, .se0_req(sq), .loc_conn,
    .drv_se0, .a_conn, .se0, .j);
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  // Waits for a level to rise, or counts how long it stays high.
  task automatic await(ref logic s);
    for (n = 0; n < 99 && s !== 1'b1; n++) cyc(1);
  endtask : await
  task automatic span(ref logic s);
    for (n = 0; n < 99 && s === 1'b1; n++) cyc(1);
  endtask : span
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    st = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : bus
  task automatic ws(input logic [12:0] v);
    bus(1'b0, SA, '0);
    for (int i = 0; i < 20 && st[12:0] !== v; i++) bus(1'b0, SA, '0);
    chk(32'(st[12:0]), 32'(v));
  endtask : ws
  task automatic t_srp();
    bus(1'b1, CT, 32'h8);
    bse <= 1'b1;
    sq <= 1'b1;
    await(srp_drive);
    chk(32'(srp_ind), 32'h1);
    span(srp_drive);
    chk(n, SRPC + 1);
    @(posedge core_clk);
    sq <= 1'b0;
    ws(otg_pkg::b_idle);
    chk(32'(st[21]), 32'h1);
    cyc(20);
    chk(32'(srp_fail), 32'h0);
    await(srp_fail);
    chk(32'({srp_fail, srp_ind}), 32'h2);
    bus(1'b1, otg_pkg::CMD_OFF, 32'h2);
    cyc(2);
    chk(32'(srp_fail), 32'h0);
  endtask : t_srp
  task automatic t_bper();
    bus(1'b1, CT, 32'h40);
    bsv <= 1'b1;
    ws(otg_pkg::b_peripheral);
    chk(32'(st[16]), 32'h1);
    sq <= 1'b1;
    await(hs);
    chk(32'(hs), 32'h1);
    cyc(1);
    chk(32'(hs), 32'h0);
    @(posedge core_clk);
    sq <= 1'b0;
    acc <= 1'b1;
    bus(1'b1, CT, 32'h58);
    ws(otg_pkg::b_wait_acon);
    chk(32'(st[16]), 32'h0);
    await(drv_se0);
    span(drv_se0);
    chk(n, RSTC + 1);
    cyc(1);
    chk(32'(loc_sof), 32'h1);
    ws(otg_pkg::b_host);
    bus(1'b1, CT, 32'h50);
    ws(otg_pkg::b_peripheral);
    chk(32'(st[17]), 32'h0);
    acc <= 1'b0;
    bsv <= 1'b0;
    ws(otg_pkg::b_idle);
  endtask : t_bper
  task automatic a_up();
    bus(1'b1, CT, 32'h1);
    {avv, asv, bc} <= 3'b111;
    ws(otg_pkg::a_host);
    bus(1'b1, CT, 32'h204);
    ws(otg_pkg::a_suspend);
  endtask : a_up
  task automatic t_a();
    bus(1'b1, CT, '0);
    id <= 1'b0;
    ws(otg_pkg::a_idle);
    a_up();
    bus(1'b1, CT, 32'h5);
    ws(otg_pkg::a_host);
    bus(1'b1, CT, 32'h204);
    ws(otg_pkg::a_suspend);
    bc <= 1'b0;
    ws(otg_pkg::a_peripheral);
    chk(32'(st[19:16]), 32'h9);
    cyc(12);
    bus(1'b0, SA, '0);
    chk(32'(st[12:0]), 32'h20);
    ws(otg_pkg::a_wait_bcon);
    chk(32'(st[16]), 32'h0);
    bc <= 1'b1;
    ws(otg_pkg::a_suspend);
    cyc(6);
    bus(1'b0, SA, '0);
    chk(32'(st[12:0]), 32'h10);
    ws(otg_pkg::a_wait_vfall);
    asv <= 1'b0;
    ws(otg_pkg::a_idle);
    // A remote session request, with a_susp_req still set in CTRL, brings the port up to a_suspend.
    {asv, srp_det} <= 2'b11;
    ws(otg_pkg::a_suspend);
    bus(1'b1, CT, 32'h4);
    srp_det <= 1'b0;
    k_line <= 1'b1;
    ws(otg_pkg::a_host);
    chk(32'(st[18:17]), 32'h1);
    k_line <= 1'b0;
    bus(1'b1, CT, 32'h204);
    ws(otg_pkg::a_suspend);
    avv <= 1'b0;
    ws(otg_pkg::a_vbus_err);
    chk(32'(st[19]), 32'h0);
    cyc(10);
    bus(1'b0, SA, '0);
    chk(32'(st[12:0]), 32'h80);
    bus(1'b1, otg_pkg::CMD_OFF, 32'h1);
    ws(otg_pkg::a_wait_vfall);
    asv <= 1'b0;
    ws(otg_pkg::a_idle);
    a_up();
    bc <= 1'b0;
    ws(otg_pkg::a_peripheral);
    bus(1'b1, CT, 32'h6);
    ws(otg_pkg::a_wait_vfall);
    chk(32'(st[19:16]), 32'h0);
  endtask : t_a
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(4);
    bus(1'b0, 12'h0fc, '0);
    chk(32'({perr, st[0]}), 32'h2);
    ws(otg_pkg::b_idle);
    t_srp();
    t_bper();
    t_a();
    tally_and_finish();
  end
endmodule : otg_role_state_machine_bench
